/* File: rtl/tlic_defs.svh */
// constants of the two-level interrupt controller
`ifndef TLIC_DEFS_SVH
`define TLIC_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TLIC_IDX_ENABLE 16'h0000
`define TLIC_IDX_PRIO 16'h0001
`define TLIC_IDX_TC 16'h0002
`define TLIC_IDX_STAT 16'h0003
`define TLIC_IDX_DCFG 16'h87ff

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TLIC_ENABLE_GLOBAL 7
`define TLIC_TC_TRIG0 0
`define TLIC_TC_TRIG1 1
`define TLIC_DCFG_MODE 0
`define TLIC_STAT_ACT_LO 8
`define TLIC_STAT_ACT_HI 9

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TLIC_ENABLE_RST 8'h00
`define TLIC_PRIO_RST 6'h00
`define TLIC_TC_RST 2'h0
`define TLIC_DCFG_RST 8'h00

// ----------------------------------------------------------------------
// source numbers in polling order and vectors
// ----------------------------------------------------------------------
`define TLIC_SRC_EXT0 3'h0
`define TLIC_SRC_TMR0 3'h1
`define TLIC_SRC_EXT1 3'h2
`define TLIC_SRC_TMR1 3'h3
`define TLIC_SRC_SER 3'h4
`define TLIC_SRC_BUSY 3'h5
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_TMR0 16'h000b
`define TLIC_VEC_EXT1 16'h0013
`define TLIC_VEC_TMR1 16'h001b
`define TLIC_VEC_SER 16'h002b
`define TLIC_VEC_BUSY 16'h0033

`endif

/* File: rtl/tlic_pkg.sv */
// types of the two-level interrupt controller
package tlic_pkg;

    // ------------------------------------------------------------------
    // register state of the controller except the pin synchroniser flops
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] irq_enable_reg;
        logic [5:0] irq_priority_reg;
        logic [1:0] tc;
        logic [7:0] dcfg;
        logic [5:0] fl;
        logic act_hi;
        logic act_lo;
        logic req;
        logic [2:0] src;
        logic [15:0] vec;
        logic hb_d;
        logic vb_d;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tlic_state_t;

endpackage : tlic_pkg

/* File: rtl/tlic_pin_sync.sv */
// two-flop synchroniser with edge detection for an external request pin
`timescale 1ns/10ps
module tlic_pin_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin side
    input wire logic pin_n,
    // core side
    output logic level_n,
    output logic fall,
    output logic rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // two flops, then one more to find transitions; pin idles high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end else begin
            meta_reg <= pin_n;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // synchronised level and edge pulses
    assign level_n = sync_reg;
    assign fall = last_reg & ~sync_reg;
    assign rise = ~last_reg & sync_reg;
endmodule : tlic_pin_sync

/* File: rtl/tlic_ctrl.sv */
// two-level interrupt controller with apb registers and core vector port
`timescale 1ns/10ps
`include "tlic_defs.svh"
module tlic_ctrl
    import tlic_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources
    input wire logic external_request_zero_n,
    input wire logic external_request_one_n,
    input wire logic timer_zero_ovf,
    input wire logic timer_one_ovf,
    input wire logic serial_bus_req,
    input wire logic hblank,
    input wire logic vblank,
    // processor core
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [2:0] irq_source,
    input wire logic core_ack,
    input wire logic core_reti
);
    tlic_state_t st_reg;
    tlic_state_t st_next;

    logic ext0_lvl_n;
    logic ext0_fall;
    logic ext1_lvl_n;
    logic ext1_fall;
    logic ext1_rise;
    logic [5:0] raw;
    logic [5:0] pend;
    logic [5:0] pool;
    logic [2:0] cand;
    logic cand_valid;
    logic take;
    logic busy_evt;
    logic wr_en;
    logic [15:0] idx;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // lowest set bit is the highest polling rank
    function automatic logic [2:0] first_set(input logic [5:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_set

    // fixed vector of each source
    function automatic logic [15:0] vec_of(input logic [2:0] s);
        logic [15:0] v;
        v = `TLIC_VEC_BUSY;
        if (s == `TLIC_SRC_EXT0) begin
            v = `TLIC_VEC_EXT0;
        end else if (s == `TLIC_SRC_TMR0) begin
            v = `TLIC_VEC_TMR0;
        end else if (s == `TLIC_SRC_EXT1) begin
            v = `TLIC_VEC_EXT1;
        end else if (s == `TLIC_SRC_TMR1) begin
            v = `TLIC_VEC_TMR1;
        end else if (s == `TLIC_SRC_SER) begin
            v = `TLIC_VEC_SER;
        end
        return v;
    endfunction : vec_of

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    tlic_pin_sync u_sync0 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(external_request_zero_n),
        .level_n(ext0_lvl_n),
        .fall(ext0_fall),
        .rise()
    );
    tlic_pin_sync u_sync1 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_n(external_request_one_n),
        .level_n(ext1_lvl_n),
        .fall(ext1_fall),
        .rise(ext1_rise)
    );

    // ------------------------------------------------------------------
    // request gathering and arbitration
    // ------------------------------------------------------------------
    // busy event: line mode on active lines only, field mode per field
    always_comb begin
        if (st_reg.dcfg[`TLIC_DCFG_MODE]) begin
            busy_evt = hblank & ~st_reg.hb_d & ~vblank;
        end else begin
            busy_evt = vblank & ~st_reg.vb_d;
        end
    end

    // raw requests in polling order; level mode follows the pin
    always_comb begin
        raw[0] = st_reg.tc[`TLIC_TC_TRIG0] ? st_reg.fl[0] : ~ext0_lvl_n;
        raw[1] = st_reg.fl[1];
        raw[2] = st_reg.tc[`TLIC_TC_TRIG1] ? st_reg.fl[2] : ~ext1_lvl_n;
        raw[3] = st_reg.fl[3];
        raw[4] = serial_bus_req;
        raw[5] = st_reg.fl[5];
    end

    // enables, then level selection under the running handler
    always_comb begin
        pend = raw & st_reg.irq_enable_reg[5:0]
            & {6{st_reg.irq_enable_reg[`TLIC_ENABLE_GLOBAL]}};
        if (st_reg.act_hi) begin
            pool = 6'h00;
        end else if (st_reg.act_lo) begin
            pool = pend & st_reg.irq_priority_reg;
        end else if ((pend & st_reg.irq_priority_reg) != 6'h00) begin
            pool = pend & st_reg.irq_priority_reg;
        end else begin
            pool = pend;
        end
        cand_valid = (pool != 6'h00);
        cand = first_set(pool);
    end

    // a request is taken when the core answers the raised request
    assign take = st_reg.req & core_ack;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign idx = paddr[17:2];
    assign wr_en = psel & penable & pwrite & st_reg.pready;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.hb_d = hblank;
        st_next.vb_d = vblank;

        // vectoring clears latched edge and event flags of the source
        if (take) begin
            if (st_reg.src == `TLIC_SRC_EXT0 || st_reg.src == `TLIC_SRC_EXT1 ||
                st_reg.src == `TLIC_SRC_TMR0 || st_reg.src == `TLIC_SRC_TMR1 ||
                st_reg.src == `TLIC_SRC_BUSY) begin
                st_next.fl[st_reg.src] = 1'b0;
            end
            if (st_reg.irq_priority_reg[st_reg.src]) begin
                st_next.act_hi = 1'b1;
            end else begin
                st_next.act_lo = 1'b1;
            end
        end else if (core_reti) begin
            // return releases the innermost level
            if (st_reg.act_hi) begin
                st_next.act_hi = 1'b0;
            end else begin
                st_next.act_lo = 1'b0;
            end
        end

        // new events are set after the clear so that they win
        if (st_reg.tc[`TLIC_TC_TRIG0] && ext0_fall) begin
            st_next.fl[0] = 1'b1;
        end
        if (st_reg.tc[`TLIC_TC_TRIG1] && (ext1_fall || ext1_rise)) begin
            st_next.fl[2] = 1'b1;
        end
        if (timer_zero_ovf) begin
            st_next.fl[1] = 1'b1;
        end
        if (timer_one_ovf) begin
            st_next.fl[3] = 1'b1;
        end
        if (busy_evt) begin
            st_next.fl[5] = 1'b1;
        end

        // request and vector to the core; dropped for one cycle on take
        st_next.req = cand_valid & ~take;
        if (cand_valid && !take) begin
            st_next.src = cand;
            st_next.vec = vec_of(cand);
        end

        // apb: ready in the access cycle, data prepared in setup
        st_next.pready = psel & ~penable;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            st_next.prdata = 32'h0000_0000;
            if (idx == `TLIC_IDX_ENABLE) begin
                st_next.prdata = {24'h000000, st_reg.irq_enable_reg};
            end else if (idx == `TLIC_IDX_PRIO) begin
                st_next.prdata = {26'h0000000, st_reg.irq_priority_reg};
            end else if (idx == `TLIC_IDX_TC) begin
                st_next.prdata = {30'h00000000, st_reg.tc};
            end else if (idx == `TLIC_IDX_STAT) begin
                st_next.prdata = {22'h000000, st_reg.act_hi, st_reg.act_lo,
                                  2'h0, pend};
            end else if (idx == `TLIC_IDX_DCFG) begin
                st_next.prdata = {24'h000000, st_reg.dcfg};
            end else begin
                st_next.pslverr = 1'b1;
            end
        end
        if (wr_en) begin
            if (idx == `TLIC_IDX_ENABLE) begin
                st_next.irq_enable_reg = {pwdata[7], 1'b0, pwdata[5:0]};
            end else if (idx == `TLIC_IDX_PRIO) begin
                st_next.irq_priority_reg = pwdata[5:0];
            end else if (idx == `TLIC_IDX_TC) begin
                st_next.tc = pwdata[1:0];
            end else if (idx == `TLIC_IDX_DCFG) begin
                st_next.dcfg = pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.irq_enable_reg <= `TLIC_ENABLE_RST;
            st_reg.irq_priority_reg <= `TLIC_PRIO_RST;
            st_reg.tc <= `TLIC_TC_RST;
            st_reg.dcfg <= `TLIC_DCFG_RST;
            st_reg.vec <= `TLIC_VEC_EXT0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq_req = st_reg.req;
    assign irq_vector = st_reg.vec;
    assign irq_source = st_reg.src;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_global_off;
        @(posedge pclk) disable iff (!presetn)
        !st_reg.irq_enable_reg[`TLIC_ENABLE_GLOBAL] |-> !cand_valid ##1 !st_reg.req;
    endproperty
    a_global_off: assert property (p_global_off) else $error("request while globally off");

    property p_masked;
        @(posedge pclk) disable iff (!presetn)
        cand_valid |-> st_reg.irq_enable_reg[cand] && pend[cand];
    endproperty
    a_masked: assert property (p_masked) else $error("disabled source selected");

    property p_hi_blocks;
        @(posedge pclk) disable iff (!presetn)
        st_reg.act_hi |=> !st_reg.req;
    endproperty
    a_hi_blocks: assert property (p_hi_blocks) else $error("request during high handler");

    property p_lo_preempt;
        @(posedge pclk) disable iff (!presetn)
        st_reg.act_lo && cand_valid |-> st_reg.irq_priority_reg[cand];
    endproperty
    a_lo_preempt: assert property (p_lo_preempt) else $error("low preempts low");

    property p_hi_first;
        @(posedge pclk) disable iff (!presetn)
        (pend & st_reg.irq_priority_reg) != 6'h00 && !st_reg.act_hi
            |-> cand_valid && st_reg.irq_priority_reg[cand];
    endproperty
    a_hi_first: assert property (p_hi_first) else $error("low chosen over high");

    property p_poll;
        @(posedge pclk) disable iff (!presetn)
        cand_valid |-> (pool & ((6'h01 << cand) - 6'h01)) == 6'h00;
    endproperty
    a_poll: assert property (p_poll) else $error("polling order broken");

    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        cand_valid && !take && cand == `TLIC_SRC_BUSY |=> st_reg.vec == 16'h0033;
    endproperty
    a_vector: assert property (p_vector) else $error("wrong busy vector");

    property p_take_level;
        @(posedge pclk) disable iff (!presetn)
        take |=> !st_reg.req && (st_reg.act_hi || st_reg.act_lo);
    endproperty
    a_take_level: assert property (p_take_level) else $error("level not held");

    property p_reti;
        @(posedge pclk) disable iff (!presetn)
        core_reti && !take && st_reg.act_hi |=> !st_reg.act_hi && $stable(st_reg.act_lo);
    endproperty
    a_reti: assert property (p_reti) else $error("return did not release");

    property p_line_busy;
        @(posedge pclk) disable iff (!presetn)
        st_reg.dcfg[`TLIC_DCFG_MODE] && hblank && !st_reg.hb_d && !vblank |=> st_reg.fl[5];
    endproperty
    a_line_busy: assert property (p_line_busy) else $error("busy event lost");
endmodule : tlic_ctrl

/* File: sim/tlic_core_model.sv */
// processor core model that takes offered vectors and returns from handlers
`timescale 1ns/10ps
module tlic_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controller side
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [2:0] irq_source,
    output logic core_ack,
    output logic core_reti,
    // bench side
    input wire logic [1:0] ack_delay,
    input wire logic reti_cmd,
    output logic [7:0] take_cnt,
    output logic [2:0] take_src,
    output logic [15:0] take_vec
);
    logic [1:0] wait_cnt;

    // acknowledge after a set wait, log each hardware call, return on command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ack <= 1'h0;
            core_reti <= 1'h0;
            wait_cnt <= 2'h0;
            take_cnt <= 8'h0;
            take_src <= 3'h0;
            take_vec <= 16'h0;
        end else begin
            core_reti <= reti_cmd;
            if (core_ack && irq_req) begin
                take_cnt <= take_cnt + 8'h1;
                take_src <= irq_source;
                take_vec <= irq_vector;
            end
            if (irq_req && !core_ack && wait_cnt == ack_delay) begin
                core_ack <= 1'h1;
                wait_cnt <= 2'h0;
            end else begin
                core_ack <= 1'h0;
                wait_cnt <= (irq_req && !core_ack) ? wait_cnt + 2'h1 : 2'h0;
            end
        end
    end
endmodule : tlic_core_model

/* File: sim/test_two_level_interrupt_controller.sv */
// self-checking bench of the two-level interrupt controller
`timescale 1ns/10ps
`include "tlic_defs.svh"
module test_two_level_interrupt_controller;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, irq_req, core_ack, core_reti, reti_cmd = 1'h0;
    logic ext0_n = 1'h1, ext1_n = 1'h1, tmr0 = 1'h0, tmr1 = 1'h0;
    logic ser = 1'h0, hb = 1'h0, vb = 1'h0;
    logic [15:0] irq_vector, take_vec;
    logic [2:0] irq_source, take_src;
    logic [7:0] take_cnt, exp_takes = 8'h0;
    logic [1:0] ack_delay = 2'h0;
    logic [5:0] en_mask, prio_mask;
    int fail_count = 0, comparisons = 0;

    always #2 pclk = ~pclk;

    tlic_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_request_zero_n(ext0_n), .external_request_one_n(ext1_n),
        .timer_zero_ovf(tmr0), .timer_one_ovf(tmr1), .serial_bus_req(ser), .hblank(hb),
        .vblank(vb), .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source),
        .core_ack(core_ack), .core_reti(core_reti));

    tlic_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_source(irq_source), .core_ack(core_ack),
        .core_reti(core_reti), .ack_delay(ack_delay), .reti_cmd(reti_cmd),
        .take_cnt(take_cnt), .take_src(take_src), .take_vec(take_vec));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task results;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // vector of each source in polling order
    function automatic logic [15:0] vec_of(input logic [2:0] s);
        case (s)
            3'h0: return 16'h0003;
            3'h1: return 16'h000b;
            3'h2: return 16'h0013;
            3'h3: return 16'h001b;
            3'h4: return 16'h002b;
            default: return 16'h0033;
        endcase
    endfunction : vec_of

    // one apb transfer; waits for pready and takes data at that edge
    task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        // access phase holds until the edge that sees pready high
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0);
        chk(name, exp, rd);
    endtask : rd_chk

    // raise the sources in the mask in one cycle; pulses last one cycle
    task raise(input logic [5:0] m);
        @(posedge pclk);
        if (m[0]) ext0_n <= 1'h0;
        if (m[1]) tmr0 <= 1'h1;
        if (m[2]) ext1_n <= 1'h0;
        if (m[3]) tmr1 <= 1'h1;
        if (m[4]) ser <= 1'h1;
        if (m[5]) hb <= 1'h1;
        @(posedge pclk);
        tmr0 <= 1'h0;
        tmr1 <= 1'h0;
        hb <= 1'h0;
    endtask : raise

    // wait for the next call, check it, then drop the level source it served
    task service(input logic [2:0] s);
        int n;
        n = 0;
        while (take_cnt !== exp_takes + 8'h1 && n < 300) begin
            @(negedge pclk);
            n++;
        end
        chk("take_cnt", {24'h0, exp_takes + 8'h1}, {24'h0, take_cnt});
        exp_takes = exp_takes + 8'h1;
        chk("take_src", {29'h0, s}, {29'h0, take_src});
        chk("take_vec", {16'h0, vec_of(s)}, {16'h0, take_vec});
        @(posedge pclk);
        if (s == 3'h0) ext0_n <= 1'h1;
        if (s == 3'h2) ext1_n <= 1'h1;
        if (s == 3'h4) ser <= 1'h0;
        repeat (4) @(posedge pclk);
    endtask : service

    task reti;
        @(posedge pclk);
        reti_cmd <= 1'h1;
        @(posedge pclk);
        reti_cmd <= 1'h0;
        repeat (2) @(posedge pclk);
    endtask : reti

    task quiet(input int n);
        repeat (n) begin
            @(negedge pclk);
            chk("irq_req", 32'h0, {31'h0, irq_req});
        end
    endtask : quiet

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(74));
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rd_chk("enable", `TLIC_IDX_ENABLE, 32'h0);
        rd_chk("priority", `TLIC_IDX_PRIO, 32'h0);
        rd_chk("tc", `TLIC_IDX_TC, 32'h0);
        rd_chk("dcfg", `TLIC_IDX_DCFG, 32'h0);
        apb(1'h1, `TLIC_IDX_ENABLE, 32'hff);
        rd_chk("enable", `TLIC_IDX_ENABLE, 32'hbf);
        apb(1'h1, 16'h0004, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'h1, `TLIC_IDX_DCFG, 32'h1);
        rd_chk("dcfg", `TLIC_IDX_DCFG, 32'h1);
        // random enables and levels; the last round clears every latched flag
        for (int r = 0; r < 6; r++) begin
            en_mask = (r == 5) ? 6'h3f : 6'($urandom);
            prio_mask = 6'($urandom);
            ack_delay <= 2'($urandom);
            apb(1'h1, `TLIC_IDX_ENABLE, {26'h0, en_mask});
            apb(1'h1, `TLIC_IDX_PRIO, {26'h0, prio_mask});
            raise(6'h3f);
            quiet(8);
            apb(1'h1, `TLIC_IDX_ENABLE, {24'h0, 2'h2, en_mask});
            for (int l = 1; l >= 0; l--) begin
                for (int s = 0; s < 6; s++) begin
                    if (en_mask[s] && prio_mask[s] == l[0]) begin
                        service(3'(s));
                        reti;
                    end
                end
            end
            @(posedge pclk);
            ext0_n <= 1'h1;
            ext1_n <= 1'h1;
            ser <= 1'h0;
        end
        // nesting of low and high handlers
        apb(1'h1, `TLIC_IDX_PRIO, 32'h09);
        apb(1'h1, `TLIC_IDX_ENABLE, 32'hbf);
        raise(6'h02);
        service(3'h1);
        raise(6'h10);
        quiet(10);
        raise(6'h08);
        service(3'h3);
        // both levels active, serial still pending and enabled
        rd_chk("stat", `TLIC_IDX_STAT, 32'h310);
        raise(6'h01);
        quiet(10);
        reti;
        service(3'h0);
        reti;
        quiet(10);
        reti;
        service(3'h4);
        reti;
        // edge triggered external inputs
        apb(1'h1, `TLIC_IDX_TC, 32'h3);
        apb(1'h1, `TLIC_IDX_PRIO, 32'h0);
        raise(6'h01);
        service(3'h0);
        reti;
        quiet(10);
        raise(6'h04);
        service(3'h2);
        reti;
        service(3'h2);
        reti;
        quiet(10);
        // display busy in field then line mode
        apb(1'h1, `TLIC_IDX_ENABLE, 32'ha0);
        apb(1'h1, `TLIC_IDX_DCFG, 32'h0);
        raise(6'h20);
        quiet(8);
        @(posedge pclk);
        vb <= 1'h1;
        service(3'h5);
        reti;
        apb(1'h1, `TLIC_IDX_DCFG, 32'h1);
        raise(6'h20);
        quiet(8);
        @(posedge pclk);
        vb <= 1'h0;
        quiet(8);
        raise(6'h20);
        service(3'h5);
        reti;
        results;
    end

    initial begin
        repeat (30000) @(posedge pclk);
        fail_count++;
        $display("mismatch watchdog expected finish seen timeout");
        results;
    end
endmodule : test_two_level_interrupt_controller
